// file: logic/hmx_line_cond.sv
/*
 * hmx_line_cond: two-flop synchronisers for the bus lines and address
 * pins, plus edge, start and stop detection. Assumes the pins are
 * asynchronous to i_clock and much slower than it.
 */
`timescale 1ns/1ps
module hmx_line_cond (
	input  wire logic i_clock,
	input  wire logic i_nrst,
	input  wire logic i_scl,
	input  wire logic i_sda,
	input  wire logic i_addr_select_pin_high,
	input  wire logic i_addr_select_pin_low,
	hmx_line_if.src   ln
);

	// stage 0 is the metastable catcher, stage 1 the clean level,
	// stage 2 the previous clean level
	typedef struct packed {
		logic [2:0] scl;
		logic [2:0] sda;
		logic [1:0] pin_meta;
		logic [1:0] pin;
	} hmx_cond_s;

	hmx_cond_s r;
	hmx_cond_s next_r;

	// shift the sync chains
	always_comb begin
		next_r          = r;
		next_r.scl      = {r.scl[1:0], i_scl};
		next_r.sda      = {r.sda[1:0], i_sda};
		next_r.pin_meta = {i_addr_select_pin_high, i_addr_select_pin_low};
		next_r.pin      = r.pin_meta;
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			r.scl      <= hmx_pkg::HMX_LINE_RST;
			r.sda      <= hmx_pkg::HMX_LINE_RST;
			r.pin_meta <= hmx_pkg::HMX_PIN_RST;
			r.pin      <= hmx_pkg::HMX_PIN_RST;
		end else begin
			r <= next_r;
		end
	end

	// events look only at stages 1 and 2
	assign ln.scl_rise = r.scl[1] & ~r.scl[2];
	assign ln.scl_fall = ~r.scl[1] & r.scl[2];
	assign ln.sda      = r.sda[1];
	assign ln.start    = r.scl[1] & r.scl[2] & ~r.sda[1] & r.sda[2];
	assign ln.stop     = r.scl[1] & r.scl[2] & r.sda[1] & ~r.sda[2];
	assign ln.addr_lo  = r.pin;

endmodule

// file: logic/hmx_line_if.sv
/*
 * hmx_line_if: conditioned bus events passed from the line conditioner
 * to the protocol engine. Both ends sit on the system clock.
 */
`timescale 1ns/1ps
interface hmx_line_if;
	logic       scl_rise;
	logic       scl_fall;
	logic       sda;
	logic       start;
	logic       stop;
	logic [1:0] addr_lo;

	modport src (output scl_rise, scl_fall, sda, start, stop, addr_lo);
	modport dst (input  scl_rise, scl_fall, sda, start, stop, addr_lo);
endinterface

// file: logic/hmx_pkg.sv
/*
 * hmx_pkg: constants and types of the hex mux switch controller.
 * Assumes a two-wire target port oversampled by a fast system clock.
 */
package hmx_pkg;

	localparam int        HMX_NMUX       = 6;
	localparam logic [4:0] HMX_ADDR_FIXED = 5'h14;  // upper five address bits 10100
	localparam logic [3:0] HMX_BYTE_BITS  = 4'h8;
	localparam logic [3:0] HMX_CNT_RST    = 4'h0;

	// second data byte field positions
	localparam int HMX_LOAD_POS = 0;  // load_switches_bit
	localparam int HMX_RSTN_POS = 1;  // soft_reset_n_bit

	// command byte fields
	localparam int        HMX_ACTION_POS = 7;  // command_action_bit
	localparam logic [6:0] HMX_CMD_ALL_A  = 7'h00;
	localparam logic [6:0] HMX_CMD_ALL_B  = 7'h01;
	localparam logic [6:0] HMX_CMD_ONE_LO = 7'h02;
	localparam logic [6:0] HMX_CMD_ONE_HI = 7'h0d;
	localparam logic [6:0] HMX_CMD_DIS_LO = 7'h0e;
	localparam logic [6:0] HMX_CMD_DIS_HI = 7'h13;
	localparam logic [6:0] HMX_CMD_DIS_ALL = 7'h1f;

	// reset values
	localparam logic [5:0] HMX_SW_RST   = 6'h00;
	localparam logic [7:0] HMX_BYTE_RST = 8'h00;
	localparam logic [2:0] HMX_LINE_RST = 3'h7;  // idle bus reads high
	localparam logic [1:0] HMX_PIN_RST  = 2'h0;

	typedef enum logic [6:0] {
		ST_IDLE     = 7'h01,
		ST_ADDR     = 7'h02,
		ST_ADDR_ACK = 7'h04,
		ST_WR       = 7'h08,
		ST_WR_ACK   = 7'h10,
		ST_RD       = 7'h20,
		ST_RD_ACK   = 7'h40
	} hmx_state_e;

endpackage

// file: logic/hmx_switch_ctrl.sv
/*
 * hmx_switch_ctrl: two-wire target port controlling six 2:1 muxes.
 * Assumes an open-drain SDA resolved outside from o_sda_oe, and an
 * i_clock much faster than the bus so that line edges are oversampled.
 */
// Overview of operation
// - target only; never drives the clock
// - start on SDA fall with SCL high
// - shift eight bits, address then direction
// - matching address acknowledged on ninth pulse
// - non-matching device idles until next start
// - direction one reads, zero writes
// - each byte is eight bits plus acknowledge
// - SDA changes only while SCL low
// - stop on SDA rise with SCL high
// - address is 10100 then two pins
// - write is address plus sixteen data bits
// - byte one command, byte two mode bits
// - bit seven action; codes 0, 1 all
// - codes 2 to 13 pick one switch
// - commands combine to build a configuration
// - latest command on a switch wins
// - pending commands applied when load bit high
// - power-up or soft reset opens all switches
// - codes 0x0e-0x13 open one mux, 0x1f with action bit zero all
// - read returns two acknowledged status bytes
`timescale 1ns/1ps
module hmx_switch_ctrl (
	input  wire logic       i_clock,
	input  wire logic       i_nrst,
	input  wire logic       i_scl,
	input  wire logic       i_sda,
	input  wire logic       i_addr_select_pin_high,
	input  wire logic       i_addr_select_pin_low,
	output logic            o_sda_out,
	output logic            o_sda_oe,
	output logic [5:0]      o_mux_side_a_on,
	output logic [5:0]      o_mux_side_b_on
);

	typedef struct packed {
		hmx_pkg::hmx_state_e st;
		logic [3:0]          cnt;
		logic [7:0]          rx;
		logic [7:0]          tx;
		logic                rw;
		logic                second;
		logic                rd_sel;
		logic [7:0]          cmd;
		logic [5:0]          pend_a;
		logic [5:0]          pend_b;
		logic [5:0]          sw_a;
		logic [5:0]          sw_b;
		logic                sda_oe;
		logic                sda_out;
	} hmx_ctrl_s;

	hmx_ctrl_s  r;
	hmx_ctrl_s  next_r;
	hmx_line_if ln ();
	logic [6:0] own_addr;
	logic       word_done;
	logic [11:0] cmd_res;

	hmx_line_cond u_cond (
		.i_clock                (i_clock),
		.i_nrst                 (i_nrst),
		.i_scl                  (i_scl),
		.i_sda                  (i_sda),
		.i_addr_select_pin_high (i_addr_select_pin_high),
		.i_addr_select_pin_low  (i_addr_select_pin_low),
		.ln                     (ln)
	);

	// pins go after the fixed bits, high pin first
	assign own_addr = {hmx_pkg::HMX_ADDR_FIXED, ln.addr_lo};

	// apply one command to a switch image {a, b}; later calls overwrite
	// earlier ones, so the latest command on a switch wins
	function automatic logic [11:0] apply_cmd(
		input logic [7:0] cmd,
		input logic [5:0] a,
		input logic [5:0] b
	);
		logic [6:0] lo;
		logic       on;
		logic [5:0] na;
		logic [5:0] nb;
		lo = cmd[6:0];
		on = cmd[hmx_pkg::HMX_ACTION_POS];
		na = a;
		nb = b;
		if (lo == hmx_pkg::HMX_CMD_ALL_A) begin
			na = {6{on}};
		end else if (lo == hmx_pkg::HMX_CMD_ALL_B) begin
			nb = {6{on}};
		end else if (lo >= hmx_pkg::HMX_CMD_ONE_LO && lo <= hmx_pkg::HMX_CMD_ONE_HI) begin
			for (int i = 0; i < hmx_pkg::HMX_NMUX; i++) begin
				// code 2n+2 side a of mux n+1, odd code side b
				if (lo[6:1] == 6'(i + 1)) begin
					if (lo[0]) begin
						nb[i] = on;
					end else begin
						na[i] = on;
					end
				end
			end
		end else if (lo >= hmx_pkg::HMX_CMD_DIS_LO && lo <= hmx_pkg::HMX_CMD_DIS_HI) begin
			// action bit does not matter for a mux disable
			for (int i = 0; i < hmx_pkg::HMX_NMUX; i++) begin
				if (lo == 7'(i) + hmx_pkg::HMX_CMD_DIS_LO) begin
					na[i] = 1'b0;
					nb[i] = 1'b0;
				end
			end
		end else if (lo == hmx_pkg::HMX_CMD_DIS_ALL && !on) begin
			na = hmx_pkg::HMX_SW_RST;
			nb = hmx_pkg::HMX_SW_RST;
		end
		// anything else is reserved and leaves the image alone
		return {na, nb};
	endfunction

	// status byte: first byte muxes 6..5, second byte muxes 4..1,
	// each mux as {side b, side a}; one means closed
	function automatic logic [7:0] status_byte(
		input logic       sel,
		input logic [5:0] a,
		input logic [5:0] b
	);
		logic [7:0] v;
		v = hmx_pkg::HMX_BYTE_RST;
		if (!sel) begin
			v = {4'h0, b[5], a[5], b[4], a[4]};
		end else begin
			v = {b[3], a[3], b[2], a[2], b[1], a[1], b[0], a[0]};
		end
		return v;
	endfunction

	// the second data byte completes on this falling edge
	assign word_done = (r.st == hmx_pkg::ST_WR) && ln.scl_fall
		&& (r.cnt == hmx_pkg::HMX_BYTE_BITS) && r.second;
	assign cmd_res = apply_cmd(r.cmd, r.pend_a, r.pend_b);

	// protocol engine; SDA only moves on a falling SCL so that the
	// controller never sees a false start or stop from us
	always_comb begin
		next_r         = r;
		next_r.sda_out = 1'b0;
		if (ln.start) begin
			// restart also drops any half received word
			next_r.st     = hmx_pkg::ST_ADDR;
			next_r.cnt    = hmx_pkg::HMX_CNT_RST;
			next_r.second = 1'b0;
			next_r.sda_oe = 1'b0;
		end else if (ln.stop) begin
			next_r.st     = hmx_pkg::ST_IDLE;
			next_r.second = 1'b0;
			next_r.sda_oe = 1'b0;
		end else begin
			unique case (r.st)
				hmx_pkg::ST_IDLE: begin
					next_r.sda_oe = 1'b0;
				end
				hmx_pkg::ST_ADDR: begin
					if (ln.scl_rise) begin
						next_r.rx  = {r.rx[6:0], ln.sda};
						next_r.cnt = r.cnt + 4'h1;
					end else if (ln.scl_fall && r.cnt == hmx_pkg::HMX_BYTE_BITS) begin
						if (r.rx[7:1] == own_addr) begin
							next_r.st     = hmx_pkg::ST_ADDR_ACK;
							next_r.sda_oe = 1'b1;
							next_r.rw     = r.rx[0];
						end else begin
							next_r.st = hmx_pkg::ST_IDLE;
						end
					end
				end
				hmx_pkg::ST_ADDR_ACK: begin
					if (ln.scl_fall) begin
						next_r.cnt = hmx_pkg::HMX_CNT_RST;
						if (r.rw) begin
							// read: first status bit goes out at once
							next_r.st     = hmx_pkg::ST_RD;
							next_r.tx     = status_byte(1'b0, r.sw_a, r.sw_b);
							next_r.rd_sel = 1'b1;
							next_r.sda_oe = ~next_r.tx[7];
						end else begin
							next_r.st     = hmx_pkg::ST_WR;
							next_r.second = 1'b0;
							next_r.sda_oe = 1'b0;
						end
					end
				end
				hmx_pkg::ST_WR: begin
					if (ln.scl_rise) begin
						next_r.rx  = {r.rx[6:0], ln.sda};
						next_r.cnt = r.cnt + 4'h1;
					end else if (ln.scl_fall && r.cnt == hmx_pkg::HMX_BYTE_BITS) begin
						// every data byte is acknowledged, valid or not
						next_r.st     = hmx_pkg::ST_WR_ACK;
						next_r.sda_oe = 1'b1;
						if (!r.second) begin
							next_r.cmd    = r.rx;
							next_r.second = 1'b1;
						end else begin
							next_r.second = 1'b0;
							if (!r.rx[hmx_pkg::HMX_RSTN_POS]) begin
								next_r.pend_a = hmx_pkg::HMX_SW_RST;
								next_r.pend_b = hmx_pkg::HMX_SW_RST;
								next_r.sw_a   = hmx_pkg::HMX_SW_RST;
								next_r.sw_b   = hmx_pkg::HMX_SW_RST;
							end else begin
								next_r.pend_a = cmd_res[11:6];
								next_r.pend_b = cmd_res[5:0];
								if (r.rx[hmx_pkg::HMX_LOAD_POS]) begin
									next_r.sw_a = cmd_res[11:6];
									next_r.sw_b = cmd_res[5:0];
								end
							end
						end
					end
				end
				hmx_pkg::ST_WR_ACK: begin
					if (ln.scl_fall) begin
						next_r.st     = hmx_pkg::ST_WR;
						next_r.cnt    = hmx_pkg::HMX_CNT_RST;
						next_r.sda_oe = 1'b0;
					end
				end
				hmx_pkg::ST_RD: begin
					if (ln.scl_rise) begin
						next_r.cnt = r.cnt + 4'h1;
					end else if (ln.scl_fall) begin
						if (r.cnt == hmx_pkg::HMX_BYTE_BITS) begin
							// hand the line back for the controller's ack
							next_r.st     = hmx_pkg::ST_RD_ACK;
							next_r.sda_oe = 1'b0;
						end else begin
							next_r.tx     = {r.tx[6:0], 1'b0};
							next_r.sda_oe = ~r.tx[6];
						end
					end
				end
				hmx_pkg::ST_RD_ACK: begin
					if (ln.scl_rise) begin
						if (ln.sda) begin
							// not-acknowledge ends our part of the read
							next_r.st = hmx_pkg::ST_IDLE;
						end else begin
							next_r.tx     = status_byte(r.rd_sel, r.sw_a, r.sw_b);
							next_r.rd_sel = ~r.rd_sel;
						end
					end else if (ln.scl_fall) begin
						next_r.st     = hmx_pkg::ST_RD;
						next_r.cnt    = hmx_pkg::HMX_CNT_RST;
						next_r.sda_oe = ~r.tx[7];
					end
				end
				default: begin
					next_r.st     = hmx_pkg::ST_IDLE;
					next_r.sda_oe = 1'b0;
				end
			endcase
		end
	end

	// power-up leaves every switch open
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			r.st      <= hmx_pkg::ST_IDLE;
			r.cnt     <= hmx_pkg::HMX_CNT_RST;
			r.rx      <= hmx_pkg::HMX_BYTE_RST;
			r.tx      <= hmx_pkg::HMX_BYTE_RST;
			r.rw      <= 1'b0;
			r.second  <= 1'b0;
			r.rd_sel  <= 1'b0;
			r.cmd     <= hmx_pkg::HMX_BYTE_RST;
			r.pend_a  <= hmx_pkg::HMX_SW_RST;
			r.pend_b  <= hmx_pkg::HMX_SW_RST;
			r.sw_a    <= hmx_pkg::HMX_SW_RST;
			r.sw_b    <= hmx_pkg::HMX_SW_RST;
			r.sda_oe  <= 1'b0;
			r.sda_out <= 1'b0;
		end else begin
			r <= next_r;
		end
	end

	// outputs are the state flops themselves
	assign o_sda_out       = r.sda_out;
	assign o_sda_oe        = r.sda_oe;
	assign o_mux_side_a_on = r.sw_a;
	assign o_mux_side_b_on = r.sw_b;

	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_nrst);

	AST_OPEN_DRAIN:
	assert property (o_sda_oe |-> !o_sda_out)
		else $error("sda driven high");

	AST_START_ARMS:
	assert property (ln.start |=> r.st == hmx_pkg::ST_ADDR && r.cnt == 4'h0 && !o_sda_oe)
		else $error("start did not arm address phase");

	AST_ADDR_SHIFT:
	assert property (r.st == hmx_pkg::ST_ADDR && ln.scl_rise && !ln.start && !ln.stop
		|=> r.cnt == $past(r.cnt) + 4'h1 && r.rx[0] == $past(ln.sda))
		else $error("address bit not shifted in");

	AST_ACK_MATCH:
	assert property (r.st == hmx_pkg::ST_ADDR && ln.scl_fall && r.cnt == 4'h8
		&& r.rx[7:1] == own_addr && !ln.start && !ln.stop
		|=> o_sda_oe && r.st == hmx_pkg::ST_ADDR_ACK)
		else $error("matching address not acknowledged");

	AST_NOMATCH_IDLE:
	assert property (r.st == hmx_pkg::ST_ADDR && ln.scl_fall && r.cnt == 4'h8
		&& r.rx[7:1] != own_addr && !ln.start && !ln.stop
		|=> r.st == hmx_pkg::ST_IDLE && !o_sda_oe)
		else $error("foreign address not ignored");

	AST_IDLE_QUIET:
	assert property (r.st == hmx_pkg::ST_IDLE |-> !o_sda_oe)
		else $error("sda driven while idle");

	AST_SDA_ON_LOW_SCL:
	assert property (!ln.scl_fall && !ln.start && !ln.stop |=> $stable(o_sda_oe))
		else $error("sda moved outside scl low");

	AST_STOP_ENDS:
	assert property (ln.stop && !ln.start |=> r.st == hmx_pkg::ST_IDLE && !r.second)
		else $error("stop did not end transfer");

	AST_ONE_SWITCH:
	assert property (word_done && r.cmd == 8'h85 && r.rx[1:0] == 2'h3
		|=> o_mux_side_b_on[1] && o_mux_side_a_on == $past(r.pend_a))
		else $error("single switch command misapplied");

	AST_LOAD_APPLIES:
	assert property (word_done && r.rx[1:0] == 2'h3
		|=> o_mux_side_a_on == r.pend_a && o_mux_side_b_on == r.pend_b)
		else $error("load bit did not apply pending image");

	AST_NOLOAD_HOLDS:
	assert property (word_done && r.rx[1:0] == 2'h2
		|=> $stable(o_mux_side_a_on) && $stable(o_mux_side_b_on))
		else $error("switches moved without load bit");

	AST_SOFT_RESET:
	assert property (word_done && !r.rx[1]
		|=> o_mux_side_a_on == 6'h00 && o_mux_side_b_on == 6'h00 ##1 r.pend_a == 6'h00)
		else $error("soft reset left a switch closed");

	AST_RESERVED_KEEP:
	assert property (word_done && r.cmd[6:0] == 7'h14 && r.rx[1]
		|=> $stable(r.pend_a) && $stable(r.pend_b) && o_sda_oe)
		else $error("reserved code changed state or lost ack");

	AST_READ_FIRST_BIT:
	assert property (r.st == hmx_pkg::ST_ADDR_ACK && r.rw && ln.scl_fall
		&& !ln.start && !ln.stop
		|=> r.st == hmx_pkg::ST_RD && o_sda_oe == !r.tx[7])
		else $error("read did not present status");

	AST_PARTIAL_DROP:
	assert property (r.second && (ln.start || ln.stop)
		|=> !r.second && $stable(o_mux_side_a_on) && $stable(r.pend_b))
		else $error("partial word was not discarded");

endmodule

// file: testbench/hmx_ctl_model.sv
/*
 * hmx_ctl_model: two-wire bus controller that drives the switch block.
 * Assumes the bench resolves SDA from o_sda_low, the device's enable and a pull-up.
 */
`timescale 1ns/1ps
module hmx_ctl_model (
	input  wire logic i_link_clock,
	input  wire logic i_sda,
	output logic      o_scl,
	output logic      o_sda_low
);
	logic [15:0] rdata;
	logic        nack;
	int          slow;
	event        done_ev;

	// bus idles released; clock stands high between frames
	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
		nack = 1'b0;
		rdata = 16'h0;
		slow = 0;
	end

	// one pulse: data moves while the clock is low, sampled mid-high
	task automatic bit_io(input logic b, output logic r);
		o_sda_low = !b;
		repeat (1 + slow) @(posedge i_link_clock);
		o_scl = 1'b1;
		@(posedge i_link_clock);
		r = i_sda;
		@(posedge i_link_clock);
		o_scl = 1'b0;
		@(posedge i_link_clock);
	endtask

	// start or repeated start; entered with the clock high or low
	task automatic start_cond();
		o_sda_low = 1'b0;
		@(posedge i_link_clock);
		o_scl = 1'b1;
		@(posedge i_link_clock);
		o_sda_low = 1'b1;
		@(posedge i_link_clock);
		o_scl = 1'b0;
		@(posedge i_link_clock);
	endtask

	// data goes low before the tenth pulse, rises while it is high
	task automatic stop_cond();
		o_sda_low = 1'b1;
		@(posedge i_link_clock);
		o_scl = 1'b1;
		@(posedge i_link_clock);
		o_sda_low = 1'b0;
		repeat (2) @(posedge i_link_clock);
	endtask

	// eight bits, most significant first, then the acknowledge pulse
	task automatic send_byte(input logic [7:0] d, output logic ack_n);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, ack_n);
	endtask

	// write; nb data bytes (fewer than two leaves a partial word)
	task automatic wr(input logic [6:0] adr, input logic [7:0] cmd,
			input logic [7:0] mode, input int nb, input logic stp);
		logic ack_adr;
		logic ack_cmd;
		logic ack_mode;
		ack_cmd = 1'b0;
		ack_mode = 1'b0;
		start_cond();
		send_byte({adr, 1'b0}, ack_adr);
		if (nb > 0) send_byte(cmd, ack_cmd);
		if (nb > 1) send_byte(mode, ack_mode);
		if (stp) stop_cond();
		nack = ack_adr | ack_cmd | ack_mode;
		->done_ev;
	endtask

	// read two status bytes, acknowledge the first, refuse the second
	task automatic rd(input logic [6:0] adr);
		logic r;
		start_cond();
		send_byte({adr, 1'b1}, nack);
		for (int i = 15; i >= 0; i--) begin
			bit_io(1'b1, rdata[i]);
			if (i == 8 || i == 0) bit_io(i == 0, r);
		end
		stop_cond();
		->done_ev;
	endtask
endmodule

// file: testbench/hmx_switch_ctrl_tb.sv
/*
 * hmx_switch_ctrl_tb: self-checking bench for the hex mux switch block.
 * Assumes hmx_pkg, the design and hmx_ctl_model are compiled first.
 */
`timescale 1ns/1ps
module hmx_switch_ctrl_tb;
	typedef struct packed {
		logic       rd;
		logic [5:0] a;
		logic [5:0] b;
	} hmx_note_s;

	logic       i_clock;
	logic       i_nrst;
	logic       link_clock;
	logic       scl;
	logic       sda_low;
	logic       sda_out;
	logic       sda_oe;
	logic       sda_wire;
	logic [1:0] pins;
	logic [5:0] mux_a;
	logic [5:0] mux_b;
	logic [5:0] pa;
	logic [5:0] pb;
	logic [5:0] ea;
	logic [5:0] eb;
	logic [7:0] m;
	hmx_note_s  got;
	hmx_note_s  notes[$];
	int         num_errors;
	int         n_compared;

	// clocks: link tick period 30 ns, rising link edges never meet the 4 ns clock
	initial i_clock = 1'b0;
	always #2 i_clock = ~i_clock;
	initial link_clock = 1'b0;
	always #15 link_clock = ~link_clock;

	// open-drain data line with a pull-up
	assign sda_wire = !(sda_oe || sda_low);

	hmx_switch_ctrl dut_u (
		.i_clock(i_clock), .i_nrst(i_nrst), .i_scl(scl), .i_sda(sda_wire),
		.i_addr_select_pin_high(pins[1]), .i_addr_select_pin_low(pins[0]),
		.o_sda_out(sda_out), .o_sda_oe(sda_oe),
		.o_mux_side_a_on(mux_a), .o_mux_side_b_on(mux_b)
	);

	hmx_ctl_model ctl_u (
		.i_link_clock(link_clock), .i_sda(sda_wire), .o_scl(scl), .o_sda_low(sda_low)
	);

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic summarize();
		if (num_errors == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	function automatic logic [6:0] addr();
		return {hmx_pkg::HMX_ADDR_FIXED, pins};
	endfunction

	// status image: a then b per mux, mux 1 in the low bits
	function automatic logic [15:0] stat(input logic [5:0] a, input logic [5:0] b);
		logic [15:0] s;
		s = 16'h0;
		for (int i = 0; i < 6; i++) begin
			s[2 * i] = a[i];
			s[2 * i + 1] = b[i];
		end
		return s;
	endfunction

	// one command byte applied to a pending image; unlisted codes do nothing
	function automatic logic [11:0] apply(input logic [7:0] c, input logic [11:0] s);
		logic [6:0] k;
		logic [5:0] a;
		logic [5:0] b;
		k = c[6:0];
		{a, b} = s;
		if (k == 7'h00) a = c[7] ? 6'h3f : 6'h00;
		else if (k == 7'h01) b = c[7] ? 6'h3f : 6'h00;
		else if (k <= 7'h0d) begin
			if (k[0]) b[k[3:1] - 3'd1] = c[7];
			else a[k[3:1] - 3'd1] = c[7];
		end else if (k <= 7'h13) begin
			a[k - 7'h0e] = 1'b0;
			b[k - 7'h0e] = 1'b0;
		end else if (k == 7'h1f && !c[7]) begin
			a = 6'h00;
			b = 6'h00;
		end
		return {a, b};
	endfunction

	// full write: update the reference, note it, run the bus
	task automatic do_wr(input logic [7:0] c, input logic [7:0] md);
		if (!md[1]) {pa, pb, ea, eb} = 24'h0;
		else begin
			{pa, pb} = apply(c, {pa, pb});
			if (md[0]) {ea, eb} = {pa, pb};
		end
		notes.push_back({1'b0, ea, eb});
		ctl_u.wr(addr(), c, md, 2, 1'b1);
		check("write ack", 16'(ctl_u.nack), 16'h0);
	endtask

	// clear first if the command would close both sides of a mux
	task automatic safe_wr(input logic [7:0] c, input logic [7:0] md);
		logic [11:0] s;
		s = apply(c, {pa, pb});
		if ((s[11:6] & s[5:0]) != 6'h0) do_wr(8'h1f, 8'h03);
		do_wr(c, md);
	endtask

	task automatic do_rd();
		notes.push_back({1'b1, ea, eb});
		ctl_u.rd(addr());
		check("read ack", 16'(ctl_u.nack), 16'h0);
	endtask

	task automatic hw_reset();
		@(negedge i_clock);
		i_nrst = 1'b0;
		repeat (6) @(negedge i_clock);
		i_nrst = 1'b1;
		repeat (8) @(negedge i_clock);
		{pa, pb, ea, eb} = 24'h0;
		check("reset", {3'h0, sda_oe, mux_a, mux_b}, 16'h0);
	endtask

	// each finished transfer is compared with the oldest note
	always begin
		@(ctl_u.done_ev);
		got = notes.pop_front();
		check("switches", {4'h0, mux_a, mux_b}, {4'h0, got.a, got.b});
		check("sda out", 16'(sda_out), 16'h0);
		if (got.rd) check("status", ctl_u.rdata, stat(got.a, got.b));
	end

	// watchdog sized well above the planned traffic
	initial begin
		#380000;
		num_errors++;
		summarize();
	end

	initial begin
		num_errors = 0;
		n_compared = 0;
		pins = 2'h0;
		i_nrst = 1'b0;
		void'($urandom(32'hdeab442b));
		pins = 2'($urandom);
		hw_reset();
		// other addresses are ignored and change nothing
		for (int i = 0; i < 7; i += 2) begin
			notes.push_back({1'b0, ea, eb});
			ctl_u.wr(addr() ^ (7'h01 << i), 8'h80, 8'h03, 2, 1'b1);
			check("foreign ack", 16'(ctl_u.nack), 16'h1);
		end
		// codes 0 to 31, random action and load
		for (int k = 0; k < 32; k++) begin
			safe_wr({1'($urandom), 2'h0, 5'(k)}, {6'h0, 1'b1, 1'($urandom)});
			if (k % 8 == 7) do_rd();
		end
		// partial words by stop and by repeated start are dropped
		notes.push_back({1'b0, ea, eb});
		ctl_u.wr(addr(), 8'h82, 8'h03, 1, 1'b1);
		notes.push_back({1'b0, ea, eb});
		ctl_u.wr(addr(), 8'h83, 8'h03, 1, 1'b0);
		do_wr(8'h11, 8'h03);
		// mux 2 side b closed with load, so the single switch check is reached
		safe_wr(8'h85, 8'h03);
		// random traffic, pins, slow clocking and soft resets
		for (int j = 0; j < 20; j++) begin
			@(negedge i_clock);
			pins = 2'($urandom);
			repeat (8) @(negedge i_clock);
			ctl_u.slow = $urandom % 2;
			m = 8'($urandom);
			if ($urandom % 6 != 0) m[1] = 1'b1;
			safe_wr(8'($urandom), m);
			if ($urandom % 3 == 0) do_rd();
		end
		hw_reset();
		do_wr(8'h82, 8'h03);
		do_rd();
		summarize();
	end
endmodule
